// ==== hw/uart_baud_rx.v ====
// baud rate generator and serial receiver with ahb-lite register slave
`include "uart_rx_defs.vh"

module uart_baud_rx (
  // clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // ahb-lite slave
  input  wire        hsel,
  input  wire [7:0]  haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  // serial pins
  input  wire        sck_in,
  output reg         sck_out,
  output reg         sck_oe,
  input  wire        rxd
);

  localparam ST_IDLE  = 2'h0;
  localparam ST_START = 2'h1;
  localparam ST_BITS  = 2'h2;

  // --------------------------------------------------------------------------
  // register bus
  // --------------------------------------------------------------------------
  reg  [31:0] mode_q;
  reg  [15:0] baud_div_q;
  reg  [15:0] timeout_val_q;
  reg  [7:0]  rx_hold_q;
  reg         rx_on_q;
  reg         rx_char_available_q;
  reg         rx_overrun_flag_q;
  reg         frame_q;
  reg         check_bit_error_flag_q;
  reg         tmo_q;
  reg         wr_pend_q;
  reg         rd_pend_q;
  reg  [7:0]  addr_q;

  wire        take   = hsel & hready & htrans[1];
  wire        wr_now = wr_pend_q;
  wire        cr_wr  = wr_now & (addr_q == `OFS_CONTROL);
  wire        clr_st = cr_wr & hwdata[`CR_CLEAR_STATUS];
  wire        rearm  = cr_wr & hwdata[`CR_REARM_IDLE];
  wire        rhr_rd = take & ~hwrite & (haddr == `OFS_RX_HOLD);
  wire        sync_m = mode_q[`MR_SYNC];
  wire        ext_ck = mode_q[`MR_CLKSEL_HI];
  wire [2:0]  par_m  = mode_q[`MR_PAR_HI:`MR_PAR_LO];

  wire [31:0] status = {15'h0000, rx_on_q, 7'h00, tmo_q, check_bit_error_flag_q, frame_q, rx_overrun_flag_q, 4'h0, rx_char_available_q};

  reg  [31:0] rd_d;
  always @* begin
    case (haddr)
      `OFS_MODE:       rd_d = mode_q;
      `OFS_STATUS:     rd_d = status;
      `OFS_RX_HOLD:    rd_d = {24'h000000, rx_hold_q};
      `OFS_BAUD_DIV:   rd_d = {16'h0000, baud_div_q};
      `OFS_RX_TIMEOUT: rd_d = {16'h0000, timeout_val_q};
      default:         rd_d = 32'h0000_0000;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q     <= 1'b0;
      rd_pend_q     <= 1'b0;
      addr_q        <= 8'h00;
      hrdata        <= 32'h0000_0000;
      hreadyout     <= 1'b1;
      hresp         <= 1'b0;
      mode_q        <= `MR_RESET;
      baud_div_q    <= 16'h0000;
      timeout_val_q <= 16'h0000;
      rx_on_q       <= 1'b0;
    end else begin
      wr_pend_q <= take & hwrite;
      rd_pend_q <= take & ~hwrite;
      if (take)
        addr_q <= haddr;
      if (take & ~hwrite)
        hrdata <= rd_d;
      if (wr_now) begin
        case (addr_q)
          `OFS_MODE:       mode_q <= hwdata;
          `OFS_BAUD_DIV:   baud_div_q <= hwdata[15:0];
          `OFS_RX_TIMEOUT: timeout_val_q <= hwdata[15:0];
          default:         mode_q <= mode_q;
        endcase
      end
      if (cr_wr & hwdata[`CR_RX_DISABLE])
        rx_on_q <= 1'b0;
      else if (cr_wr & hwdata[`CR_RX_ENABLE])
        rx_on_q <= 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // baud generator
  // --------------------------------------------------------------------------
  reg        sck_s_q;
  reg        sck_p_q;
  reg        sck_d_q;
  reg  [3:0] div8_q;
  reg  [15:0] div_q;
  reg        ck16_q;

  // edge is taken behind the two-flop synchroniser only
  wire       sck_rise = sck_p_q & ~sck_d_q;
  wire       src_tick = ext_ck ? sck_rise :
                        (mode_q[`MR_CLKSEL_LO] ? (div8_q == `SYS_DIV8 - 4'h1) : 1'b1);
  // tick of the divided clock: 16x sample clock in async, baud clock in sync with the internal clock (external sync uses sck_rise)
  wire       div_tick = (baud_div_q != 16'h0000) & src_tick & (div_q == 16'h0001);
  wire       sync_ext = sync_m & ext_ck;
  wire       samp_tick = sync_m ? 1'b0 : div_tick;
  wire       baud_tick = sync_ext ? sck_rise : (sync_m ? div_tick : 1'b0);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sck_s_q <= 1'b0;
      sck_p_q <= 1'b0;
      sck_d_q <= 1'b0;
      div8_q  <= 4'h0;
      div_q   <= 16'h0001;
      ck16_q  <= 1'b0;
      sck_out <= 1'b0;
      sck_oe  <= 1'b0;
    end else begin
      sck_s_q <= sck_in;
      sck_p_q <= sck_s_q;
      sck_d_q <= sck_p_q;
      div8_q  <= (div8_q == `SYS_DIV8 - 4'h1) ? 4'h0 : div8_q + 4'h1;
      if (baud_div_q == 16'h0000)
        div_q <= 16'h0001;
      else if (src_tick)
        div_q <= (div_q <= 16'h0001) ? baud_div_q : div_q - 16'h0001;
      if (div_tick)
        ck16_q <= ~ck16_q;
      sck_oe  <= ~ext_ck & mode_q[`MR_CLOCK_OUTPUT_ENABLE];
      sck_out <= ck16_q;
    end
  end

  // --------------------------------------------------------------------------
  // receiver
  // --------------------------------------------------------------------------
  reg  [1:0] st_q;
  reg  [4:0] cnt_q;
  reg  [3:0] bit_q;
  reg  [9:0] shf_q;
  reg  [3:0] bcnt_q;
  reg        armed_q;
  reg        run_q;
  reg  [17:0] tcnt_q;

  wire       async_go = (st_q == ST_BITS) & samp_tick & (cnt_q == 5'h00);
  wire       sync_go  = (st_q == ST_BITS) & baud_tick;
  wire       smp      = async_go | sync_go;
  wire       has_par  = (par_m != `PAR_NONE);
  wire [3:0] last_bit = has_par ? 4'h9 : 4'h8;
  wire       done     = smp & (bit_q == last_bit);
  wire [9:0] frm      = {rxd, shf_q[9:1]};
  wire [7:0] dat      = has_par ? frm[7:0] : frm[8:1];
  wire       pbit     = frm[8];
  wire       stopb    = frm[9];

  reg        exp_par;
  always @* begin
    case (par_m)
      `PAR_EVEN:  exp_par = ^dat;
      `PAR_ODD:   exp_par = ~(^dat);
      `PAR_SPACE: exp_par = 1'b0;
      `PAR_MARK:  exp_par = 1'b1;
      default:    exp_par = pbit;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q      <= ST_IDLE;
      cnt_q     <= 5'h00;
      bit_q     <= 4'h0;
      shf_q     <= 10'h000;
      rx_hold_q <= 8'h00;
      rx_char_available_q   <= 1'b0;
      rx_overrun_flag_q    <= 1'b0;
      frame_q   <= 1'b0;
      check_bit_error_flag_q    <= 1'b0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          cnt_q <= 5'h00;
          bit_q <= 4'h0;
          if (rx_on_q & sync_m & baud_tick & ~rxd)
            st_q <= ST_BITS;
          else if (rx_on_q & ~sync_m & samp_tick & ~rxd)
            st_q <= ST_START;
        end
        ST_START: begin
          if (samp_tick) begin
            if (rxd)
              st_q <= ST_IDLE;
            else if (cnt_q == `START_MIN - 5'h01) begin
              st_q  <= ST_BITS;
              cnt_q <= `FIRST_SAMPLE - `START_MIN - 5'h01;
            end else
              cnt_q <= cnt_q + 5'h01;
          end
        end
        ST_BITS: begin
          if (samp_tick & (cnt_q != 5'h00))
            cnt_q <= cnt_q - 5'h01;
          if (smp) begin
            cnt_q <= `OVERSAMPLE - 5'h01;
            shf_q <= frm;
            bit_q <= bit_q + 4'h1;
            if (done)
              st_q <= ST_IDLE;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
      if (done) begin
        rx_hold_q <= dat;
        rx_char_available_q   <= 1'b1;
      end else if (rhr_rd)
        rx_char_available_q <= 1'b0;
      if (done & rx_char_available_q & ~rhr_rd)
        rx_overrun_flag_q <= 1'b1;
      else if (clr_st)
        rx_overrun_flag_q <= 1'b0;
      if (done & has_par & (pbit != exp_par))
        check_bit_error_flag_q <= 1'b1;
      else if (clr_st)
        check_bit_error_flag_q <= 1'b0;
      if (done & ~stopb & (dat != 8'h00))
        frame_q <= 1'b1;
      else if (clr_st)
        frame_q <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // idle timeout
  // --------------------------------------------------------------------------
  wire       bit_end = sync_m ? baud_tick : (samp_tick & (bcnt_q == 4'hf));

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bcnt_q  <= 4'h0;
      armed_q <= 1'b1;
      run_q   <= 1'b0;
      tcnt_q  <= 18'h00000;
      tmo_q   <= 1'b0;
    end else begin
      if (samp_tick)
        bcnt_q <= bcnt_q + 4'h1;
      if (timeout_val_q == 16'h0000) begin
        run_q <= 1'b0;
      end else if (rearm) begin
        armed_q <= 1'b1;
        run_q   <= 1'b0;
      end else if (done) begin
        armed_q <= 1'b0;
        run_q   <= 1'b1;
        tcnt_q  <= {timeout_val_q, `TIMEOUT_MULT};
      end else if (run_q & bit_end) begin
        tcnt_q <= tcnt_q - 18'h00001;
        if (tcnt_q == 18'h00001)
          run_q <= 1'b0;
      end
      if (run_q & bit_end & (tcnt_q == 18'h00001) & ~done & (timeout_val_q != 16'h0000))
        tmo_q <= 1'b1;
      else if (rearm)
        tmo_q <= 1'b0;
    end
  end

endmodule

// ==== hw/uart_rx_defs.vh ====
// register offsets, field positions, reset values and command codes for the baud generator and receiver
`ifndef UART_RX_DEFS_VH
`define UART_RX_DEFS_VH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define OFS_CONTROL       8'h00
`define OFS_MODE          8'h04
`define OFS_STATUS        8'h08
`define OFS_RX_HOLD       8'h0c
`define OFS_BAUD_DIV      8'h10
`define OFS_RX_TIMEOUT    8'h14

// ----------------------------------------------------------------------------
// control register command bits (write only, self clearing)
// ----------------------------------------------------------------------------
`define CR_RX_ENABLE      4
`define CR_RX_DISABLE     5
`define CR_CLEAR_STATUS   8
`define CR_REARM_IDLE     11

// ----------------------------------------------------------------------------
// mode register fields
// ----------------------------------------------------------------------------
`define MR_CLKSEL_LO      4
`define MR_CLKSEL_HI      5
`define MR_SYNC           7
`define MR_PAR_LO         9
`define MR_PAR_HI         11
`define MR_CLOCK_OUTPUT_ENABLE           18
`define MR_RESET          32'h0000_0000

// ----------------------------------------------------------------------------
// parity modes
// ----------------------------------------------------------------------------
`define PAR_EVEN          3'h0
`define PAR_ODD           3'h1
`define PAR_SPACE         3'h2
`define PAR_MARK          3'h3
`define PAR_NONE          3'h4

// ----------------------------------------------------------------------------
// status register bits
// ----------------------------------------------------------------------------
`define SR_RX_CHAR_AVAILABLE          0
`define SR_OVERRUN        5
`define SR_FRAME          6
`define SR_PARITY         7
`define SR_TIMEOUT        8
`define SR_RX_ON          16

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define SYS_DIV8          4'h8
`define OVERSAMPLE        5'h10
`define START_MIN         5'h07
`define FIRST_SAMPLE      5'h18
// low two bits appended to the timeout value: value times four bit periods
`define TIMEOUT_MULT      2'h0

`endif

// ==== dv/uart_line_model.sv ====
// remote serial transmitter on the receive data and clock pins
module uart_line_model (
  // clock
  input  logic hclk,
  // line
  output logic rxd,
  output logic sck_in
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    rxd = 1'b1;
    sck_in = 1'b0;
  end
  // start, 8 data bits lsb first, optional check bit, stop; clock only inside frames
  task automatic send(input logic [7:0] d, input logic pen, pb, sb, input int bitc, input logic ext);
    logic [10:0] f;
    f = {sb, pb, d, 1'b0};
    if (!pen) begin
      f[9] = sb;
    end
    for (int i = 0; i < (pen ? 11 : 10); i++) begin
      rxd <= f[i];
      sck_in <= 1'b0;
      repeat (bitc / 2) @(posedge hclk);
      sck_in <= ext;
      repeat (bitc - bitc / 2) @(posedge hclk);
    end
    rxd <= 1'b1;
    sck_in <= 1'b0;
  endtask
  task automatic low(input int n);
    rxd <= 1'b0;
    repeat (n) @(posedge hclk);
    rxd <= 1'b1;
  endtask
endmodule

// ==== dv/uart_baud_rx_assertions.sv ====
// concurrent checks on the bus and clock pin ports of the receiver
`include "uart_rx_defs.vh"
module uart_baud_rx_assertions (
  // clock and reset
  input logic        hclk,
  input logic        hresetn,
  // bus
  input logic        hsel,
  input logic [7:0]  haddr,
  input logic [1:0]  htrans,
  input logic        hwrite,
  input logic [31:0] hwdata,
  input logic        hready,
  input logic [31:0] hrdata,
  // pin
  input logic        sck_oe
);
  // ---------------------------------------------------------------
  // shadow of the bus transfers
  // ---------------------------------------------------------------
  logic        ap_q, wr_q, dp_q, lw_q, rx_on_q, rto_q;
  logic [7:0]  a_q, la_q;
  logic [31:0] lwd_q, mode_q;
  logic [1:0]  age_q;
  wire dp = ap_q && hready;
  wire rd_st = dp && !wr_q && a_q == `OFS_STATUS && !dp_q;
  wire after_cr = lw_q && la_q == `OFS_CONTROL;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {ap_q, wr_q, dp_q, lw_q, rx_on_q, rto_q} <= 6'h00;
      {a_q, la_q} <= 16'h0000;
      {lwd_q, mode_q} <= 64'h0;
      age_q <= 2'h3;
    end else begin
      if (hready) begin
        ap_q <= hsel && htrans[1];
        a_q <= haddr;
        wr_q <= hwrite;
      end
      dp_q <= dp;
      age_q <= (dp && wr_q && a_q == `OFS_MODE) ? 2'h0 : (age_q == 2'h3 ? age_q : age_q + 2'h1);
      if (dp) begin
        lw_q <= wr_q;
        la_q <= a_q;
        lwd_q <= hwdata;
        if (wr_q && a_q == `OFS_MODE) begin
          mode_q <= hwdata;
        end
        if (wr_q && a_q == `OFS_CONTROL && hwdata[`CR_RX_ENABLE]) begin
          rx_on_q <= 1'b1;
        end
        if (wr_q && a_q == `OFS_RX_TIMEOUT && hwdata[15:0] != 16'h0) begin
          rto_q <= 1'b1;
        end
      end
    end
  end
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_ext_clk_input: assert property ($rose(mode_q[`MR_CLKSEL_HI]) |=> ##1 !sck_oe)
    else $error("clock pin driven with external clock");
  a_clk_out_drive: assert property (age_q == 2'h3 |-> sck_oe == (!mode_q[`MR_CLKSEL_HI] && mode_q[`MR_CLOCK_OUTPUT_ENABLE]))
    else $error("clock pin enable wrong for mode");
  a_rx_off_reset: assert property (rd_st && !rx_on_q |-> !hrdata[`SR_RX_ON])
    else $error("receiver on without enable");
  a_rx_on_cmd: assert property (rd_st && after_cr && lwd_q[`CR_RX_ENABLE] && !lwd_q[`CR_RX_DISABLE] |-> hrdata[`SR_RX_ON])
    else $error("receiver not on after enable");
  a_no_timeout: assert property (rd_st && !rto_q |-> !hrdata[`SR_TIMEOUT])
    else $error("timeout with zero value");
  a_rearm_clear: assert property (rd_st && after_cr && lwd_q[`CR_REARM_IDLE] |-> !hrdata[`SR_TIMEOUT])
    else $error("timeout still set after rearm");
  a_par_clear: assert property (rd_st && after_cr && lwd_q[`CR_CLEAR_STATUS] |-> !hrdata[`SR_PARITY])
    else $error("parity error survives clear");
  a_read_clr_rdy: assert property (rd_st && !lw_q && la_q == `OFS_RX_HOLD |-> !hrdata[`SR_RX_CHAR_AVAILABLE])
    else $error("ready still set after hold read");
  c_char_seen: cover property (rd_st && hrdata[`SR_RX_CHAR_AVAILABLE]);
  c_timeout_seen: cover property (rd_st && hrdata[`SR_TIMEOUT]);
  c_clk_driven: cover property (sck_oe);
endmodule
bind uart_baud_rx uart_baud_rx_assertions chk_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .sck_oe(sck_oe));

// ==== dv/uart_baud_rx_tb_top.sv ====
// self-checking bench for the baud generator and receiver
`include "uart_rx_defs.vh"
module uart_baud_rx_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [7:0]  haddr = 8'h00, d;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] hwdata = 32'h0, hrdata, rd;
  logic        hreadyout, hresp, sck_out, sck_oe, rxd, sck_in;
  int          failures = 0, checks = 0;
  always #20 hclk = ~hclk;
  uart_baud_rx dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .sck_in(sck_in), .sck_out(sck_out), .sck_oe(sck_oe), .rxd(rxd));
  uart_line_model line_u (.hclk(hclk), .rxd(rxd), .sck_in(sck_in));
  // ---------------------------------------------------------------
  // expectations, bus and compare
  // ---------------------------------------------------------------
  function automatic logic par(input logic [2:0] m, input logic [7:0] v);
    case (m)
      `PAR_EVEN: return ^v;
      `PAR_ODD: return ~^v;
      `PAR_SPACE: return 1'b0;
      default: return 1'b1;
    endcase
  endfunction
  function automatic logic [31:0] mode(input logic sy, input logic [1:0] sel, input logic [2:0] pm, input logic co);
    return {13'h0, co, 6'h0, pm, 1'h0, sy, 1'h0, sel, 4'h0};
  endfunction
  task automatic chk(input logic [31:0] got, exp, input string what);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic stat(input logic [31:0] e);
    ahb(1'b0, `OFS_STATUS, 32'h0);
    chk(rd & 32'h1_01e1, e | 32'h1_0000, "status");
  endtask
  task automatic rxc(input logic [7:0] v, input logic [31:0] e);
    repeat (8) @(posedge hclk);
    stat(e | 32'h1);
    ahb(1'b0, `OFS_RX_HOLD, 32'h0);
    chk(rd & 32'hff, {24'h0, v}, "data");
  endtask
  task automatic cfg(input logic [31:0] m, input logic [15:0] dv);
    ahb(1'b1, `OFS_MODE, m);
    ahb(1'b1, `OFS_BAUD_DIV, {16'h0, dv});
  endtask
  task automatic end_of_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #2_000_000;
    failures++;
    end_of_test();
  end
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(16));
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, `OFS_STATUS, 32'h0);
    chk(rd, 32'h0, "status after reset");
    ahb(1'b1, `OFS_CONTROL, 32'h10);
    stat(32'h0);
    for (int s = 0; s < 2; s++) begin
      for (int p = 0; p < 5; p++) begin
        d = 8'($urandom);
        cfg(mode(1'b0, s[1:0], p[2:0], 1'b0), s ? 16'h1 : 16'h2);
        line_u.send(d, p < 4, par(p[2:0], d), 1'b1, s ? 128 : 32, 1'b0);
        rxc(d, 32'h0);
      end
    end
    cfg(mode(1'b0, 2'h0, `PAR_EVEN, 1'b0), 16'h2);
    d = 8'($urandom);
    line_u.send(d, 1'b1, ~par(`PAR_EVEN, d), 1'b1, 32, 1'b0);
    rxc(d, 32'h80);
    ahb(1'b1, `OFS_CONTROL, 32'h100);
    stat(32'h0);
    line_u.send(8'h3c, 1'b1, par(`PAR_EVEN, 8'h3c), 1'b1, 32, 1'b0);
    line_u.send(d, 1'b1, par(`PAR_EVEN, d), 1'b1, 32, 1'b0);
    rxc(d, 32'h20);
    stat(32'h20);
    line_u.send(8'h5a, 1'b1, par(`PAR_EVEN, 8'h5a), 1'b0, 32, 1'b0);
    rxc(8'h5a, 32'h60);
    ahb(1'b1, `OFS_CONTROL, 32'h100);
    line_u.low(10);
    repeat (64) @(posedge hclk);
    stat(32'h0);
    cfg(mode(1'b0, 2'h0, `PAR_EVEN, 1'b0), 16'h0);
    line_u.send(d, 1'b1, par(`PAR_EVEN, d), 1'b1, 32, 1'b0);
    repeat (64) @(posedge hclk);
    stat(32'h0);
    cfg(mode(1'b1, 2'h0, `PAR_NONE, 1'b0), 16'h4);
    line_u.send(~d, 1'b0, 1'b0, 1'b1, 4, 1'b0);
    rxc(~d, 32'h0);
    cfg(mode(1'b1, 2'h2, `PAR_NONE, 1'b1), 16'h0);
    line_u.send(d, 1'b0, 1'b0, 1'b1, 8, 1'b1);
    rxc(d, 32'h0);
    chk({31'h0, sck_oe}, 32'h0, "clock pin enable");
    cfg(mode(1'b0, 2'h0, `PAR_EVEN, 1'b1), 16'h2);
    repeat (4) @(posedge hclk);
    chk({31'h0, sck_oe}, 32'h1, "clock pin enable");
    ahb(1'b1, `OFS_RX_TIMEOUT, 32'h1);
    line_u.send(d, 1'b1, par(`PAR_EVEN, d), 1'b1, 32, 1'b0);
    rxc(d, 32'h0);
    repeat (40) @(posedge hclk);
    stat(32'h0);
    repeat (120) @(posedge hclk);
    stat(32'h100);
    ahb(1'b1, `OFS_CONTROL, 32'h800);
    repeat (300) @(posedge hclk);
    stat(32'h0);
    end_of_test();
  end
endmodule
